// ==== hdl/sbl_boot_loader.sv ====
// Serial boot loader: mode strap, memory map decode, autobaud UART and boot protocol engine.
// Assumes all inputs are synchronous to clk and that the flash and RAM sit outside.
// What this block does
// (R1) Decode flash as twelve 8 KB sectors from FE8000H, or from 10000H in boot mode.
// (R2) Enter boot mode at reset release when low select is 1 and high select 0.
// (R3) In boot mode the flash answers at 10000H through 27FFFH only.
// (R4) In boot mode the boot ROM answers at FFF000H through FFFFFFH, over the vectors.
// (R5) Link frames are 8 data bits, no parity, one stop bit, both directions.
// (R6) Accept link rates 115200, 57600, 38400, 19200 and 9600 bps.
// (R7) Talk to the controller only over the boot serial transmit and receive pins.
// (R8) Compare the received password with the stored one; refuse RAM transfer on mismatch.
// (R9) When flash is erased the expected password is twelve bytes of FFH.
// (R10) The controller keeps the downloaded routine inside 001000H through 001DFFH.
// (R11) After a good password and routine, hand execution to the routine in RAM.
// (R12) Offer a whole-chip erase command usable without any downloaded routine.
// (R13) Interrupts stay disabled in boot mode; software polls the request flags.
// (R14) Pins not used by the link keep their reset state throughout boot mode.
// (R15) Controller rate plus oscillator error stays within -1.5% to +2%.
// (R16) First byte 86H sets the rate; echo 86H if usable, else stop for good.
// (R17) Command byte: 10H RAM transfer, 20H sum, 30H info, 40H erase, 60H protect; only 10H and 40H are served, the rest get an error acknowledge.
// (R18) After an error acknowledge, wait for a fresh command byte.
// (R19) Measure the first byte's bit timing to derive the divisor before the echo.
`timescale 1ns/10ps
`include "sbl_defines.svh"
module sbl_boot_loader #(
  parameter longint CLK_HZ = `SBL_CLK_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic boot_serial_rx,
  output logic boot_serial_tx,
  input wire logic [23:0] cpu_addr,
  output sbl_pkg::sbl_map_s map,
  input wire logic [95:0] stored_password,
  input wire logic flash_erased,
  input wire logic flash_protected,
  output sbl_pkg::sbl_ramwr_s ram_wr,
  output logic erase_req,
  input wire logic erase_done,
  output sbl_pkg::sbl_jump_s jump,
  output logic boot_mode,
  output logic irq_enable,
  output logic pins_hold
);
  localparam longint RATES [5] = '{`SBL_RATE0, `SBL_RATE1, `SBL_RATE2, `SBL_RATE3, `SBL_RATE4};

  // A period is usable when it falls inside the tolerance band of any supported rate.
  function automatic logic baud_ok(input logic [15:0] p);
    longint lo;
    longint hi;
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 5; i++) begin
      lo = (CLK_HZ * 1000 + RATES[i] * (1000 + `SBL_ERR_POS_PM) - 1)
           / (RATES[i] * (1000 + `SBL_ERR_POS_PM));
      hi = (CLK_HZ * 1000) / (RATES[i] * (1000 - `SBL_ERR_NEG_PM));
      if (longint'(p) >= lo && longint'(p) <= hi) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  sbl_pkg::sbl_state_e st_r, st_nxt;
  logic boot_r;
  logic rx_prev_r;
  logic [15:0] baud_r, baud_nxt;
  logic [15:0] meas_r, meas_nxt;
  logic [17:0] tail_r, tail_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [7:0] sum_r, sum_nxt;
  logic bad_r, bad_nxt;
  logic cerr_r, cerr_nxt;
  logic [47:0] hdr_r, hdr_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic tx_go_r, tx_go_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  sbl_pkg::sbl_ramwr_s wr_nxt;
  logic erase_nxt;
  sbl_pkg::sbl_jump_s jump_nxt;
  logic rx_busy_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_vld_r;
  logic rx_ferr_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic [15:0] tx_cnt_r;

  // Address decode; the flash window moves and the ROM appears only in boot mode.
  wire [23:0] fl_base = boot_r ? `SBL_FLASH_BASE_BOOT : `SBL_FLASH_BASE_CHIP; // [R1] [R3]
  wire [23:0] fl_rel = cpu_addr - fl_base;
  wire fl_hit = (cpu_addr >= fl_base) && (fl_rel < `SBL_FLASH_SIZE); // [R1] [R3]
  wire rom_hit = boot_r && (cpu_addr >= `SBL_ROM_BASE) && (cpu_addr <= `SBL_ROM_TOP); // [R4]
  wire [3:0] fl_sector = fl_rel[16:`SBL_SECT_LOG];
  wire [12:0] fl_offset = fl_rel[`SBL_SECT_LOG-1:0];

  // Protocol helpers; the checksum is chosen so that all bytes plus it sum to zero.
  wire [7:0] sum_add = sum_r + rx_sh_r;
  wire [7:0] pwd_exp = flash_erased ? `SBL_PWD_ERASED
                                    : stored_password[{idx_r, 3'b000} +: 8]; // [R9]
  wire [32:0] ram_end = {1'b0, hdr_r[47:16]} + {17'h0_0000, hdr_r[15:0]};
  wire range_ok = ({1'b0, hdr_r[47:16]} >= `SBL_RAM_LO) && (ram_end <= `SBL_RAM_END); // [R10]
  wire [15:0] half_meas = {1'b0, meas_r[15:1]};
  wire [17:0] tail_lim = {2'b00, baud_r} + {1'b0, baud_r, 1'b0};
  wire rx_fall = rx_prev_r && !boot_serial_rx;
  wire link_up = !(st_r inside {sbl_pkg::ST_OFF, sbl_pkg::ST_BWAIT, sbl_pkg::ST_BMEAS,
                                sbl_pkg::ST_BTAIL, sbl_pkg::ST_DEAD});
  wire tx_busy = (tx_bit_r != 4'h0) || tx_go_r;

  // Protocol engine; every byte after the sync byte arrives as a one-cycle pulse from the receiver below.
  always_comb begin
    st_nxt = st_r;
    baud_nxt = baud_r;
    meas_nxt = meas_r;
    tail_nxt = tail_r;
    idx_nxt = idx_r;
    sum_nxt = sum_r;
    bad_nxt = bad_r;
    cerr_nxt = cerr_r;
    hdr_nxt = hdr_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    tx_go_nxt = 1'b0;
    tx_byte_nxt = tx_byte_r;
    wr_nxt = '0;
    erase_nxt = 1'b0;
    jump_nxt = jump;
    unique case (st_r)
      sbl_pkg::ST_OFF: begin
        if (boot_r) begin
          st_nxt = sbl_pkg::ST_BWAIT;
        end
      end
      sbl_pkg::ST_BWAIT: begin
        meas_nxt = 16'h0000;
        if (rx_fall) begin
          st_nxt = sbl_pkg::ST_BMEAS;
        end
      end
      sbl_pkg::ST_BMEAS: begin
        // The 86H frame starts with two low bit times: start bit and data bit 0.
        if (meas_r != 16'hFFFF) begin
          meas_nxt = meas_r + 16'h0001;
        end
        if (boot_serial_rx) begin
          tail_nxt = 18'h0_0000;
          if (baud_ok(half_meas)) begin // [R6] [R15] [R19]
            baud_nxt = half_meas;
            st_nxt = sbl_pkg::ST_BTAIL;
          end else begin
            st_nxt = sbl_pkg::ST_DEAD; // [R16]
          end
        end
      end
      sbl_pkg::ST_BTAIL: begin
        // Three idle bit times mark the end of the frame; no high run inside 86H is that long.
        tail_nxt = boot_serial_rx ? tail_r + 18'h0_0001 : 18'h0_0000;
        if (tail_r >= tail_lim) begin
          tx_go_nxt = 1'b1;
          tx_byte_nxt = `SBL_SYNC_BYTE; // [R16]
          st_nxt = sbl_pkg::ST_CMD;
        end
      end
      sbl_pkg::ST_DEAD: begin
        st_nxt = sbl_pkg::ST_DEAD;
      end
      sbl_pkg::ST_CMD: begin
        if (rx_vld_r) begin
          tx_go_nxt = 1'b1;
          idx_nxt = 4'h0;
          sum_nxt = 8'h00;
          bad_nxt = 1'b0;
          cerr_nxt = 1'b0;
          if (rx_ferr_r) begin
            tx_byte_nxt = {rx_sh_r[7:4], `SBL_ACK_COMM};
          end else if (rx_sh_r == `SBL_CMD_RAM && flash_protected) begin
            tx_byte_nxt = {rx_sh_r[7:4], `SBL_ACK_PROT};
          end else if (rx_sh_r == `SBL_CMD_RAM) begin
            tx_byte_nxt = `SBL_CMD_RAM; // [R17]
            st_nxt = sbl_pkg::ST_PWD;
          end else if (rx_sh_r == `SBL_CMD_ERASE) begin
            tx_go_nxt = 1'b0;
            erase_nxt = 1'b1; // [R12] [R17]
            st_nxt = sbl_pkg::ST_ERASE;
          end else begin
            tx_byte_nxt = {rx_sh_r[7:4], `SBL_ACK_ERR}; // [R17] [R18]
          end
        end
      end
      sbl_pkg::ST_PWD: begin
        if (rx_vld_r) begin
          sum_nxt = sum_add;
          cerr_nxt = cerr_r || rx_ferr_r;
          bad_nxt = bad_r || (rx_sh_r != pwd_exp); // [R8] [R9]
          idx_nxt = idx_r + 4'h1;
          if (idx_r == 4'(`SBL_PWD_LEN - 1)) begin
            st_nxt = sbl_pkg::ST_PSUM;
          end
        end
      end
      sbl_pkg::ST_PSUM, sbl_pkg::ST_HSUM, sbl_pkg::ST_DSUM: begin
        if (rx_vld_r) begin
          tx_go_nxt = 1'b1;
          idx_nxt = 4'h0;
          sum_nxt = 8'h00;
          st_nxt = sbl_pkg::ST_CMD; // [R18]
          if (cerr_r || rx_ferr_r) begin
            tx_byte_nxt = {4'h1, `SBL_ACK_COMM};
          end else if (sum_add != 8'h00 || bad_r) begin
            tx_byte_nxt = {4'h1, `SBL_ACK_ERR}; // [R8]
          end else if (st_r == sbl_pkg::ST_HSUM && !range_ok) begin
            tx_byte_nxt = {4'h1, `SBL_ACK_ERR};
          end else begin
            tx_byte_nxt = `SBL_CMD_RAM;
            if (st_r == sbl_pkg::ST_PSUM) begin
              st_nxt = sbl_pkg::ST_HDR;
            end else if (st_r == sbl_pkg::ST_HSUM) begin
              addr_nxt = hdr_r[39:16];
              cnt_nxt = hdr_r[15:0];
              st_nxt = (hdr_r[15:0] == 16'h0000) ? sbl_pkg::ST_DSUM : sbl_pkg::ST_DATA;
            end else begin
              st_nxt = sbl_pkg::ST_JUMP;
            end
          end
        end
      end
      sbl_pkg::ST_HDR: begin
        if (rx_vld_r) begin
          sum_nxt = sum_add;
          cerr_nxt = cerr_r || rx_ferr_r;
          hdr_nxt = {hdr_r[39:0], rx_sh_r};
          idx_nxt = idx_r + 4'h1;
          if (idx_r == 4'(`SBL_HDR_LEN - 1)) begin
            st_nxt = sbl_pkg::ST_HSUM;
          end
        end
      end
      sbl_pkg::ST_DATA: begin
        if (rx_vld_r) begin
          sum_nxt = sum_add;
          cerr_nxt = cerr_r || rx_ferr_r;
          wr_nxt = '{we: 1'b1, addr: addr_r, data: rx_sh_r};
          addr_nxt = addr_r + 24'h00_0001;
          cnt_nxt = cnt_r - 16'h0001;
          if (cnt_r == 16'h0001) begin
            st_nxt = sbl_pkg::ST_DSUM;
          end
        end
      end
      sbl_pkg::ST_ERASE: begin
        if (erase_done) begin
          tx_go_nxt = 1'b1;
          tx_byte_nxt = `SBL_CMD_ERASE; // [R12]
          st_nxt = sbl_pkg::ST_CMD;
        end
      end
      sbl_pkg::ST_JUMP: begin
        // Hand over only once the last acknowledge has left the pin.
        if (!tx_busy) begin
          jump_nxt = '{valid: 1'b1, addr: hdr_r[39:16]}; // [R11]
        end
      end
      default: begin
        st_nxt = sbl_pkg::ST_OFF;
      end
    endcase
  end

  // Mode strap is caught on the last reset cycle and frozen for the session.
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_r <= mode_select_low && !mode_select_high; // [R2]
    end
  end

  // Protocol state registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= sbl_pkg::ST_OFF;
      baud_r <= 16'h0001;
      meas_r <= 16'h0000;
      tail_r <= 18'h0_0000;
      idx_r <= 4'h0;
      sum_r <= 8'h00;
      bad_r <= 1'b0;
      cerr_r <= 1'b0;
      hdr_r <= 48'h0000_0000_0000;
      cnt_r <= 16'h0000;
      addr_r <= 24'h00_0000;
      tx_go_r <= 1'b0;
      tx_byte_r <= 8'h00;
      ram_wr <= '0;
      erase_req <= 1'b0;
      jump <= '0;
    end else begin
      st_r <= st_nxt;
      baud_r <= baud_nxt;
      meas_r <= meas_nxt;
      tail_r <= tail_nxt;
      idx_r <= idx_nxt;
      sum_r <= sum_nxt;
      bad_r <= bad_nxt;
      cerr_r <= cerr_nxt;
      hdr_r <= hdr_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      tx_go_r <= tx_go_nxt;
      tx_byte_r <= tx_byte_nxt;
      ram_wr <= wr_nxt;
      erase_req <= erase_nxt;
      jump <= jump_nxt;
    end
  end

  // Registered decode and mode outputs; the map answers one cycle after the address.
  always_ff @(posedge clk) begin
    if (rst) begin
      map <= '0;
      boot_mode <= 1'b0;
      irq_enable <= 1'b0;
      pins_hold <= 1'b0;
    end else begin
      map <= '{flash_sel: fl_hit && !rom_hit, sector: fl_sector, offset: fl_offset,
               rom_sel: rom_hit}; // [R1] [R3] [R4]
      boot_mode <= boot_r;
      irq_enable <= !boot_r; // [R13]
      pins_hold <= boot_r; // [R14]
    end
  end

  // Receiver: 8N1 sampled mid-bit with the measured divisor, enabled only once the rate is set.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_prev_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_vld_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end else begin
      rx_prev_r <= boot_serial_rx; // [R7]
      rx_vld_r <= 1'b0;
      if (!rx_busy_r) begin
        if (link_up && rx_fall) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= {1'b0, baud_r[15:1]};
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != 16'h0000) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= baud_r - 16'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && boot_serial_rx) begin
          rx_busy_r <= 1'b0; // Glitch, not a start bit.
        end else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          rx_vld_r <= 1'b1;
          rx_ferr_r <= !boot_serial_rx; // [R5]
        end else if (rx_bit_r != 4'h0) begin
          rx_sh_r <= {boot_serial_rx, rx_sh_r[7:1]}; // [R5]
        end
      end
    end
  end

  // Transmitter: the shift register idles all ones, so the pin idles high.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_r <= 10'h3FF;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 16'h0000;
    end else if (tx_go_r) begin
      tx_sh_r <= {1'b1, tx_byte_r, 1'b0}; // [R5]
      tx_bit_r <= 4'hA;
      tx_cnt_r <= baud_r - 16'h0001;
    end else if (tx_bit_r != 4'h0) begin
      if (tx_cnt_r != 16'h0000) begin
        tx_cnt_r <= tx_cnt_r - 16'h0001;
      end else begin
        tx_cnt_r <= baud_r - 16'h0001;
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        tx_bit_r <= tx_bit_r - 4'h1;
      end
    end
  end

  assign boot_serial_tx = tx_sh_r[0]; // [R7]
endmodule

// ==== common/sbl_defines.svh ====
// Constants of the serial boot loader: memory map, protocol bytes, rates and tolerances.
// Assumes it is included by its bare name from design and bench files alike.
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH
`define SBL_FLASH_BASE_CHIP 24'hFE_8000
`define SBL_FLASH_BASE_BOOT 24'h01_0000
`define SBL_FLASH_SIZE 24'h01_8000
`define SBL_SECT_LOG 13
`define SBL_SECT_CNT 12
`define SBL_ROM_BASE 24'hFF_F000
`define SBL_ROM_TOP 24'hFF_FFFF
`define SBL_RAM_LO 33'h0_0000_1000
`define SBL_RAM_END 33'h0_0000_1E00
`define SBL_SYNC_BYTE 8'h86
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_SUM 8'h20
`define SBL_CMD_INFO 8'h30
`define SBL_CMD_ERASE 8'h40
`define SBL_CMD_PROT 8'h60
`define SBL_ACK_ERR 4'h1
`define SBL_ACK_PROT 4'h6
`define SBL_ACK_COMM 4'h8
`define SBL_PWD_LEN 12
`define SBL_PWD_ERASED 8'hFF
`define SBL_HDR_LEN 6
`define SBL_CLK_HZ 100000000
`define SBL_RATE0 115200
`define SBL_RATE1 57600
`define SBL_RATE2 38400
`define SBL_RATE3 19200
`define SBL_RATE4 9600
`define SBL_ERR_POS_PM 20
`define SBL_ERR_NEG_PM 15
`endif

// ==== common/sbl_pkg.sv ====
// Types shared by the serial boot loader and its bench.
// Assumes constants come from sbl_defines.svh.
package sbl_pkg;
  typedef enum logic [13:0] {
    ST_OFF = 14'h0001,
    ST_BWAIT = 14'h0002,
    ST_BMEAS = 14'h0004,
    ST_BTAIL = 14'h0008,
    ST_DEAD = 14'h0010,
    ST_CMD = 14'h0020,
    ST_PWD = 14'h0040,
    ST_PSUM = 14'h0080,
    ST_HDR = 14'h0100,
    ST_HSUM = 14'h0200,
    ST_DATA = 14'h0400,
    ST_DSUM = 14'h0800,
    ST_ERASE = 14'h1000,
    ST_JUMP = 14'h2000
  } sbl_state_e;

  typedef struct packed {
    logic flash_sel;
    logic [3:0] sector;
    logic [12:0] offset;
    logic rom_sel;
  } sbl_map_s;

  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [7:0] data;
  } sbl_ramwr_s;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } sbl_jump_s;
endpackage

// ==== tb/sbl_boot_loader_asserts.sv ====
// Port-level checks of the boot loader, bound into every instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`include "sbl_defines.svh"
module sbl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic boot_serial_tx,
  input wire logic [23:0] cpu_addr,
  input wire sbl_pkg::sbl_map_s map,
  input wire sbl_pkg::sbl_ramwr_s ram_wr,
  input wire logic erase_req,
  input wire sbl_pkg::sbl_jump_s jump,
  input wire logic boot_mode,
  input wire logic irq_enable,
  input wire logic pins_hold
);
  logic [23:0] addr_r;
  logic rst_r;
  // The decode is registered, so it is judged against last cycle's address.
  always_ff @(posedge clk) begin
    addr_r <= cpu_addr;
    rst_r <= rst;
  end
  // The first cycle after reset still shows the reset decode, so it is skipped.
  wire live = !rst && !rst_r;
  wire [23:0] b_off = addr_r - `SBL_FLASH_BASE_BOOT;
  wire [23:0] c_off = addr_r - `SBL_FLASH_BASE_CHIP;
  wire in_boot = addr_r >= `SBL_FLASH_BASE_BOOT && b_off < `SBL_FLASH_SIZE;
  wire in_chip = addr_r >= `SBL_FLASH_BASE_CHIP;
  wire in_rom = addr_r >= `SBL_ROM_BASE;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  rom_decode_a: assert property (live && boot_mode && in_rom
    |-> map.rom_sel && !map.flash_sel) else $error("boot rom decode wrong");
  boot_flash_a: assert property (live && boot_mode && in_boot
    |-> map.flash_sel && map.sector == b_off[16:13] && map.offset == b_off[12:0])
    else $error("boot flash decode wrong");
  boot_gap_a: assert property (live && boot_mode && !in_boot |-> !map.flash_sel)
    else $error("flash seen outside boot window");
  chip_map_a: assert property (live && !boot_mode |-> !map.rom_sel
    && map.flash_sel == in_chip && (!in_chip || map.sector == c_off[16:13]))
    else $error("single chip decode wrong");
  strap_catch_a: assert property ($fell(rst) |=> boot_mode ==
    ($past(mode_select_low, 2) && !$past(mode_select_high, 2))) else $error("strap missed");
  irq_mode_a: assert property (live |-> irq_enable == !boot_mode)
    else $error("interrupts enabled in boot mode");
  pins_hold_a: assert property (live |-> pins_hold == boot_mode)
    else $error("pin hold wrong");
  tx_quiet_a: assert property (!boot_mode |-> boot_serial_tx)
    else $error("link active outside boot mode");
  erase_pulse_a: assert property ($rose(erase_req) |=> !erase_req)
    else $error("erase request too long");
  ram_window_a: assert property (ram_wr.we |-> boot_mode && ram_wr.addr >= `SBL_RAM_LO
    && ram_wr.addr < `SBL_RAM_END) else $error("ram write outside window");
  jump_hold_a: assert property (jump.valid |=> jump.valid && $stable(jump.addr))
    else $error("jump dropped or moved");
  erase_c: cover property (erase_req);
  jump_c: cover property ($rose(jump.valid));
  write_c: cover property (ram_wr.we);
  rom_c: cover property (live && map.rom_sel);
endmodule
bind sbl_boot_loader sbl_asserts sbl_asserts_inst (.clk(clk), .rst(rst),
  .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
  .boot_serial_tx(boot_serial_tx), .cpu_addr(cpu_addr), .map(map), .ram_wr(ram_wr),
  .erase_req(erase_req), .jump(jump), .boot_mode(boot_mode), .irq_enable(irq_enable),
  .pins_hold(pins_hold));

// ==== tb/sbl_host_model.sv ====
// Programming controller model: 8N1 bytes at a fixed bit period, LSB first.
// Assumes tasks are called at a rising clock edge; the device line idles high.
`timescale 1ns/10ps
module sbl_host_model #(
  parameter int BIT_CYC = 87 // Within tolerance of the nominal rate.
) (
  input wire logic clk,
  input wire logic dev_tx,
  output logic dev_rx
);
  initial dev_rx = 1'b1;
  // Returns at mid-stop, since the device answers as soon as it samples the stop bit.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dev_rx <= fr[i];
      repeat (i == 9 ? BIT_CYC / 2 : BIT_CYC) @(posedge clk);
    end
  endtask
  // Samples mid-bit; ok is false on a timeout or a bad start or stop bit.
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (dev_tx !== 1'b0 && n < 60 * BIT_CYC) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk);
    ok = n < 60 * BIT_CYC && dev_tx === 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = dev_tx;
    end
    repeat (BIT_CYC) @(posedge clk);
    ok = ok && dev_tx === 1'b1;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the boot loader: strap, memory map and link protocol.
// Assumes the host model drives the receive line and watches the transmit line.
`timescale 1ns/10ps
`include "sbl_defines.svh"
module testbench;
  localparam int P = 87;
  logic clk, rst, msl, msh, erased, prot, erase_done, erase_req, boot_mode, irq_en, hold;
  logic [23:0] cpu_addr;
  logic [95:0] pwd;
  wire rx, tx;
  sbl_pkg::sbl_map_s map;
  sbl_pkg::sbl_ramwr_s ram_wr;
  sbl_pkg::sbl_jump_s jump;
  int err_total, num_checks, n_erase;
  logic [31:0] wr_q[$];
  // A lower nominal clock makes one bit 87 cycles, keeping the run short.
  sbl_boot_loader #(.CLK_HZ(10_000_000)) sbl_boot_loader_inst (.clk(clk), .rst(rst),
    .mode_select_low(msl), .mode_select_high(msh), .boot_serial_rx(rx),
    .boot_serial_tx(tx), .cpu_addr(cpu_addr), .map(map), .stored_password(pwd),
    .flash_erased(erased), .flash_protected(prot), .ram_wr(ram_wr), .erase_req(erase_req),
    .erase_done(erase_done), .jump(jump), .boot_mode(boot_mode), .irq_enable(irq_en),
    .pins_hold(hold));
  sbl_host_model #(.BIT_CYC(P)) sbl_host_model_inst (.clk(clk), .dev_tx(tx), .dev_rx(rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Flash erase finishes one cycle after it is asked; RAM writes are logged.
  always @(posedge clk) begin
    erase_done <= erase_req;
    if (erase_req === 1'b1) n_erase <= n_erase + 1;
    if (ram_wr.we === 1'b1) wr_q.push_back({ram_wr.addr, ram_wr.data});
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic hi);
    rst <= 1'b1;
    msl <= 1'b1;
    msh <= hi;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Boundary addresses in both modes; the ROM must only appear with the boot strap.
  task automatic t_map(input logic boot);
    logic [23:0] a[6] = '{24'h01_0000, 24'h02_7FFF, 24'h02_8000, 24'hFE_8000,
      24'hFF_F000, 24'hFF_FFFF};
    logic [23:0] base;
    logic fl, rom;
    do_reset(!boot);
    base = boot ? `SBL_FLASH_BASE_BOOT : `SBL_FLASH_BASE_CHIP;
    check(boot_mode, boot);
    check(irq_en, !boot);
    check(hold, boot);
    check(tx, 1'b1);
    foreach (a[i]) begin
      cpu_addr <= a[i];
      repeat (2) @(posedge clk);
      rom = boot && a[i] >= `SBL_ROM_BASE;
      fl = a[i] >= base && a[i] - base < `SBL_FLASH_SIZE && !rom;
      check({map.flash_sel, map.rom_sel}, {fl, rom});
      if (fl) check(map.sector, (a[i] - base) >> 13);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    sbl_host_model_inst.send_byte(b);
    sbl_host_model_inst.get_byte(got, ok);
    check({ok, got}, {1'b1, exp});
  endtask
  // Sends a phase with its zero-sum checksum and checks the acknowledge.
  task automatic phase(input logic [7:0] q[$], input logic [7:0] exp);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) begin
      sbl_host_model_inst.send_byte(q[i]);
      s = s - q[i];
    end
    xfer(s, exp);
  endtask
  // Autobaud, every command, refusals, then a full download and the jump.
  task automatic t_link;
    logic [7:0] cmd[5] = '{8'h20, 8'h30, 8'h60, 8'h55, 8'h20};
    logic [7:0] ff[$];
    repeat (12) ff.push_back(`SBL_PWD_ERASED);
    do_reset(1'b0);
    xfer(`SBL_SYNC_BYTE, `SBL_SYNC_BYTE);
    foreach (cmd[i])
      xfer(cmd[i], {cmd[i][7:4], 4'h1});
    xfer(`SBL_CMD_ERASE, `SBL_CMD_ERASE);
    check(n_erase, 1);
    prot <= 1'b1;
    xfer(`SBL_CMD_RAM, {4'h1, `SBL_ACK_PROT});
    prot <= 1'b0;
    xfer(`SBL_CMD_RAM, `SBL_CMD_RAM);
    phase(ff, 8'h11);
    check(wr_q.size(), 0);
    erased <= 1'b1;
    xfer(`SBL_CMD_RAM, `SBL_CMD_RAM);
    phase(ff, 8'h10);
    phase('{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02}, 8'h10);
    phase('{8'hA5, 8'h5A}, 8'h10);
    check(wr_q.size(), 2);
    check(wr_q[0], 32'h0010_00A5);
    check(wr_q[1], 32'h0010_015A);
    for (int n = 0; n < 20 * P && jump.valid !== 1'b1; n++)
      @(posedge clk);
    check(jump, {1'b1, 24'h00_1000});
  endtask
  // A first byte at no usable rate kills the link; a later good sync byte gets no echo.
  task automatic t_dead;
    logic [7:0] got;
    logic ok;
    do_reset(1'b0);
    sbl_host_model_inst.send_byte(8'h00);
    sbl_host_model_inst.send_byte(`SBL_SYNC_BYTE);
    sbl_host_model_inst.get_byte(got, ok);
    check(ok, 1'b0);
    check(boot_mode, 1'b1);
  endtask
  // Stored password differs from the erased pattern, so the flag must decide.
  initial begin
    rst = 1'b1;
    msl = 1'b1;
    msh = 1'b1;
    cpu_addr = 24'h00_0000;
    pwd = {12{8'h3C}};
    erased = 1'b0;
    prot = 1'b0;
    erase_done = 1'b0;
    n_erase = 0;
    err_total = 0;
    num_checks = 0;
    t_map(1'b0);
    t_map(1'b1);
    t_dead;
    t_link;
    tally_and_finish;
  end
  // About one and a half times the expected run, still under the cycle budget.
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
endmodule
